// ### acqst_core.sv
`timescale 1ns/1ns
`include "acqst_params.svh"
module acqst_core (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire acqst_pkg::acqst_apb_req_t apb_req,
    output acqst_pkg::acqst_apb_rsp_t     apb_rsp,
    input  wire logic                     trigger_in,
    output logic                          status_out,
    output logic                          shutter_open,
    output logic                          acquiring
);
    import acqst_pkg::*;

    acqst_state_reg_t s_reg;
    acqst_state_reg_t s_next;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Map a bus word onto the configuration fields
    function automatic acqst_cfg_t cfg_of(input logic [31:0] w);
        acqst_cfg_t c;
        c.per_frame  = w[`ACQST_CFG_PERFRAME];
        c.invert     = w[`ACQST_CFG_INVERT];
        c.src        = acqst_src_t'(w[`ACQST_CFG_SRC_HI:`ACQST_CFG_SRC_LO]);
        c.trig_mode  = acqst_trig_t'(w[`ACQST_CFG_TRIG_HI:`ACQST_CFG_TRIG_LO]);
        c.falling    = w[`ACQST_CFG_FALLING];
        c.cont_clean = w[`ACQST_CFG_CONTCLN];
        c.preopen    = w[`ACQST_CFG_PREOPEN];
        c.kinetics   = w[`ACQST_CFG_KINETICS];
        c.subframes  = w[`ACQST_CFG_SUBFRM_HI:`ACQST_CFG_SUBFRM_LO];
        return c;
    endfunction

    // Inverse of cfg_of, for reads
    function automatic logic [31:0] word_of(input acqst_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`ACQST_CFG_PERFRAME]                     = c.per_frame;
        w[`ACQST_CFG_INVERT]                       = c.invert;
        w[`ACQST_CFG_SRC_HI:`ACQST_CFG_SRC_LO]     = c.src;
        w[`ACQST_CFG_TRIG_HI:`ACQST_CFG_TRIG_LO]   = c.trig_mode;
        w[`ACQST_CFG_FALLING]                      = c.falling;
        w[`ACQST_CFG_CONTCLN]                      = c.cont_clean;
        w[`ACQST_CFG_PREOPEN]                      = c.preopen;
        w[`ACQST_CFG_KINETICS]                     = c.kinetics;
        w[`ACQST_CFG_SUBFRM_HI:`ACQST_CFG_SUBFRM_LO] = c.subframes;
        return w;
    endfunction

    // Zero-length settings still take one cycle so no phase is skipped
    function automatic logic [31:0] at_least_one(input logic [31:0] v);
        return (v == 32'h0000_0000) ? 32'h0000_0001 : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Per-cycle decodes of the bus, the trigger input and the state register
    logic        wr;
    logic        rd;
    logic        start_cmd;
    logic        stop_cmd;
    logic        trig_edge;
    logic        row_done;
    logic        cnt_done;
    logic        cond;
    logic        last_frame;
    logic [31:0] exp_len;

    // Whole next state in one process
    always_comb begin
        s_next    = s_reg;
        wr        = apb_req.psel & apb_req.penable & apb_req.pwrite;
        rd        = apb_req.psel & ~apb_req.pwrite;
        start_cmd = 1'b0;
        stop_cmd  = 1'b0;
        cond      = 1'b0;
        row_done  = (s_reg.sub == `ACQST_ROW_CYC - 16'h0001);
        cnt_done  = (s_reg.cnt == 32'h0000_0001);
        exp_len   = at_least_one(s_reg.expose);
        // A zero frame count never ends a run
        last_frame = (s_reg.frame_no + 32'h0000_0001 >= s_reg.frames) &&
                     (s_reg.frames != 32'h0000_0000);

        // Edge on the selected polarity; the input is already synchronous
        trig_edge = s_reg.live.falling ? (s_reg.trig_prev & ~trigger_in)
                                       : (~s_reg.trig_prev & trigger_in);
        // Previous level, for the edge test
        s_next.trig_prev = trigger_in;

        // Register writes
        // CTRL itself is not stored; START acts for one cycle, STOP is held in stop_req
        if (wr) begin
            unique case (apb_req.paddr)
                `ACQST_CTRL_OFF: begin
                    start_cmd = apb_req.pwdata[`ACQST_CTRL_START];
                    stop_cmd  = apb_req.pwdata[`ACQST_CTRL_STOP];
                end
                `ACQST_CFG_OFF:    s_next.cfg        = cfg_of(apb_req.pwdata);
                `ACQST_FRAMES_OFF: s_next.frames     = apb_req.pwdata;
                `ACQST_EXPOSE_OFF: s_next.expose     = apb_req.pwdata;
                `ACQST_CLEANS_OFF: s_next.cleans     = apb_req.pwdata;
                `ACQST_SHIFT_OFF:  s_next.shift_rows = apb_req.pwdata;
                `ACQST_READ_OFF:   s_next.read_rows  = apb_req.pwdata;
                `ACQST_SHUT_OFF:   s_next.shut_open  = apb_req.pwdata;
                default: ;
            endcase
        end

        // Read mux, registered on the setup cycle so data is ready in access
        if (rd & ~apb_req.penable) begin
            unique case (apb_req.paddr)
                `ACQST_CFG_OFF:    s_next.prdata = word_of(s_reg.cfg);
                `ACQST_FRAMES_OFF: s_next.prdata = s_reg.frames;
                `ACQST_EXPOSE_OFF: s_next.prdata = s_reg.expose;
                `ACQST_CLEANS_OFF: s_next.prdata = s_reg.cleans;
                `ACQST_SHIFT_OFF:  s_next.prdata = s_reg.shift_rows;
                `ACQST_READ_OFF:   s_next.prdata = s_reg.read_rows;
                `ACQST_SHUT_OFF:   s_next.prdata = s_reg.shut_open;
                `ACQST_STATUS_OFF: s_next.prdata = {s_reg.frame_no[15:0], 8'h00, 2'b00,
                                                    s_reg.acquiring, s_reg.status_out, s_reg.st};
                default:           s_next.prdata = 32'h0000_0000;
            endcase
        end

        // A stop is remembered until the sequencer reaches a frame boundary
        if (stop_cmd) begin
            s_next.stop_req = 1'b1;
        end

        // Row phase restarts with every row
        s_next.sub = (s_reg.st == ST_IDLE || row_done) ? 16'h0000 : s_reg.sub + 16'h0001;
        // Phase timer counts down and holds at zero; a phase ends at one
        if (s_reg.cnt != 32'h0000_0000) begin
            s_next.cnt = s_reg.cnt - 32'h0000_0001;
        end

        unique case (s_reg.st)
            ST_IDLE: begin
                s_next.stop_req = 1'b0;
                if (start_cmd) begin
                    // Output selection is latched only here, between runs
                    s_next.live = s_reg.cfg;
                    s_next.kin_no = 8'h00;
                    if (!s_reg.first_done || !s_reg.cfg.per_frame) begin
                        s_next.frame_no = 32'h0000_0000;
                        s_next.st  = ST_CLEAN;
                        s_next.cnt = at_least_one(s_reg.cleans) *
                                     {16'h0000, `ACQST_CLEAN_CYC};
                    end else begin
                        // Next frame of a per-frame run skips the initial cleans
                        s_next.st  = ST_PREOPEN;
                        s_next.cnt = at_least_one(s_reg.shut_open);
                    end
                end
            end
            ST_CLEAN: begin
                if (cnt_done) begin
                    // Timing mode and shutter choose how exposure is reached
                    s_next.st  = ST_PREOPEN;
                    s_next.cnt = at_least_one(s_reg.shut_open);
                end
            end
            ST_PREOPEN: begin
                // Shutter opening time; without pre-open it only precedes free run
                if (cnt_done ||
                    (s_reg.live.trig_mode != TRIG_FREE_RUN && !s_reg.live.preopen)) begin
                    if (s_reg.live.trig_mode == TRIG_FREE_RUN) begin
                        s_next.st        = ST_EXPOSE;
                        s_next.acquiring = 1'b1;
                        s_next.cnt       = exp_len;
                    end else begin
                        s_next.st        = ST_WAIT_TRIG;
                        s_next.trig_seen = 1'b0;
                    end
                end
            end
            ST_WAIT_TRIG: begin
                // An active edge starts exposure at once
                if (trig_edge) begin
                    s_next.st        = ST_EXPOSE;
                    s_next.acquiring = 1'b1;
                    s_next.cnt       = exp_len;
                end else if (s_reg.live.cont_clean && !s_reg.first_done) begin
                    // No trigger yet: run one complete clean cycle
                    s_next.st  = ST_CONT_CLEAN;
                    s_next.cnt = {16'h0000, `ACQST_CLEAN_CYC};
                end
            end
            ST_CONT_CLEAN: begin
                // An edge mid-cycle waits for the cycle end
                if (trig_edge) begin
                    s_next.trig_seen = 1'b1;
                end
                if (cnt_done) begin
                    // Check again between cycles; a trigger seen mid-cycle counts
                    if (s_reg.trig_seen || trig_edge) begin
                        s_next.st        = ST_EXPOSE;
                        s_next.acquiring = 1'b1;
                        s_next.cnt       = exp_len;
                    end else begin
                        s_next.st = ST_WAIT_TRIG;
                    end
                end
            end
            ST_EXPOSE: begin
                // Bulb mode ends exposure as soon as the input is at its inactive level
                if ((s_reg.live.trig_mode == TRIG_BULB) ?
                    (s_reg.live.falling ? trigger_in : ~trigger_in) : cnt_done) begin
                    // Rows move toward the serial register next
                    s_next.st  = ST_SHIFT;
                    s_next.cnt = at_least_one(s_reg.shift_rows) *
                                 {16'h0000, `ACQST_ROW_CYC};
                    s_next.sub = 16'h0000;
                end
            end
            ST_SHIFT: begin
                if (cnt_done) begin
                    if (s_reg.live.kinetics &&
                        s_reg.kin_no + 8'h01 < s_reg.live.subframes) begin
                        // Another subframe fits under the mask
                        s_next.kin_no = s_reg.kin_no + 8'h01;
                        // Multiple-trigger kinetics re-arms per subframe
                        s_next.st     = (s_reg.live.trig_mode == TRIG_PER_FRAME) ?
                                        ST_WAIT_TRIG : ST_EXPOSE;
                        s_next.cnt    = exp_len;
                    end else begin
                        // Whole sensor is read row by row
                        s_next.st  = ST_READOUT;
                        s_next.cnt = at_least_one(s_reg.read_rows) *
                                     {16'h0000, `ACQST_ROW_CYC};
                        s_next.sub = 16'h0000;
                    end
                end
            end
            ST_READOUT: begin
                if (cnt_done) begin
                    s_next.frame_no   = s_reg.frame_no + 32'h0000_0001;
                    s_next.first_done = 1'b1;
                    s_next.kin_no     = 8'h00;
                    if (s_reg.live.per_frame) begin
                        // Wait for the host to stop and restart
                        s_next.st = ST_HOLD;
                    end else if (s_reg.stop_req || stop_cmd || last_frame) begin
                        // Stops end a non per-frame run only here, between frames
                        s_next.st        = ST_IDLE;
                        s_next.acquiring = 1'b0;
                        s_next.first_done = 1'b0;
                    end else if (s_reg.live.trig_mode == TRIG_FREE_RUN) begin
                        s_next.st  = ST_EXPOSE;
                        s_next.cnt = exp_len;
                    end else begin
                        s_next.st = ST_WAIT_TRIG;
                    end
                end
            end
            ST_HOLD: begin
                // Per-frame: camera disabled until stop; frames=0 means free run
                if (s_reg.stop_req || stop_cmd) begin
                    s_next.st = ST_IDLE;
                    // frame_no already counts the frame just read
                    if (s_reg.frame_no >= s_reg.frames && s_reg.frames != 32'h0000_0000) begin
                        s_next.acquiring  = 1'b0;
                        s_next.first_done = 1'b0;
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase

        // A stop while idle halts a per-frame run, whatever its frame count
        // Per-frame runs rest here between frames
        if (s_reg.st == ST_IDLE && stop_cmd) begin
            s_next.acquiring  = 1'b0;
            s_next.first_done = 1'b0;
        end

        // Status condition for the live source
        // Decoded from registered state, so glitch free;
        // the price is one cycle of lag on every source
        unique case (s_reg.live.src)
            SRC_ACQUIRING:   cond = s_reg.acquiring;
            SRC_EXPOSE_EFF:  cond = (s_reg.st == ST_EXPOSE);
            SRC_EXPOSE_PROG: cond = (s_reg.st == ST_EXPOSE);
            SRC_ROW_SHIFT: begin
                // Pulse each row time, high for the first half of it; steady high during kinetics shifts
                if (s_reg.st == ST_SHIFT) begin
                    cond = s_reg.live.kinetics ? 1'b1 :
                           (s_reg.sub < (`ACQST_ROW_CYC >> 1));
                end else if (s_reg.st == ST_READOUT) begin
                    cond = s_reg.sub < (`ACQST_ROW_CYC >> 1);
                end
            end
            SRC_ALWAYS_HIGH: cond = 1'b1;
            SRC_READOUT:     cond = (s_reg.st == ST_READOUT);
            SRC_SHUTTER:     cond = (s_reg.st == ST_EXPOSE) ||
                                    (s_reg.st == ST_PREOPEN && s_reg.live.trig_mode == TRIG_FREE_RUN);
            SRC_TRIG_WAIT:   cond = (s_reg.st == ST_WAIT_TRIG) ||
                                    (s_reg.st == ST_CONT_CLEAN);
            default:         cond = 1'b0;
        endcase

        // Constant high ignores inversion; the level itself is the setting
        // so inversion never makes it a steady low
        if (s_reg.live.src == SRC_ALWAYS_HIGH) begin
            s_next.status_out = 1'b1;
        end else begin
            s_next.status_out = cond ^ s_reg.live.invert;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Reset loads the power-on settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg            <= '0;
            s_reg.st         <= ST_IDLE;
            s_reg.cfg        <= cfg_of(`ACQST_CFG_RST);
            s_reg.live       <= cfg_of(`ACQST_CFG_RST);
            s_reg.frames     <= `ACQST_FRAMES_RST;
            s_reg.expose     <= `ACQST_EXPOSE_RST;
            s_reg.cleans     <= `ACQST_CLEANS_RST;
            s_reg.shift_rows <= `ACQST_SHIFT_RST;
            s_reg.read_rows  <= `ACQST_READ_RST;
            s_reg.shut_open  <= `ACQST_SHUT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero-wait slave; unmapped addresses read zero without error
    assign apb_rsp         = '{prdata:  s_reg.prdata,
                               pready:  1'b1,
                               pslverr: 1'b0};
    assign status_out      = s_reg.status_out;
    assign acquiring       = s_reg.acquiring;
    // Opening phase counts as shutter open
    assign shutter_open    = (s_reg.st == ST_EXPOSE) || (s_reg.st == ST_PREOPEN);

endmodule

// ### acqst_params.svh
`ifndef ACQST_PARAMS_SVH
`define ACQST_PARAMS_SVH

// Register byte offsets
`define ACQST_CTRL_OFF      12'h000
`define ACQST_CFG_OFF       12'h004
`define ACQST_FRAMES_OFF    12'h008
`define ACQST_EXPOSE_OFF    12'h00C
`define ACQST_CLEANS_OFF    12'h010
`define ACQST_SHIFT_OFF     12'h014
`define ACQST_READ_OFF      12'h018
`define ACQST_SHUT_OFF      12'h01C
`define ACQST_STATUS_OFF    12'h020

// CTRL fields (write one to act)
`define ACQST_CTRL_START    0
`define ACQST_CTRL_STOP     1
// CFG fields
`define ACQST_CFG_PERFRAME  0
`define ACQST_CFG_INVERT    1
`define ACQST_CFG_SRC_LO    4
`define ACQST_CFG_SRC_HI    7
`define ACQST_CFG_TRIG_LO   8
`define ACQST_CFG_TRIG_HI   9
`define ACQST_CFG_FALLING   10
`define ACQST_CFG_CONTCLN   11
`define ACQST_CFG_PREOPEN   12
`define ACQST_CFG_KINETICS  13
`define ACQST_CFG_SUBFRM_LO 16
`define ACQST_CFG_SUBFRM_HI 23

// Reset values
`define ACQST_CFG_RST       32'h0000_0000
`define ACQST_FRAMES_RST    32'h0000_0001
`define ACQST_EXPOSE_RST    32'h0000_0064
`define ACQST_CLEANS_RST    32'h0000_0004
`define ACQST_SHIFT_RST     32'h0000_0008
`define ACQST_READ_RST      32'h0000_0020
`define ACQST_SHUT_RST      32'h0000_0010

// One clean cycle and one row shift, in pclk cycles
`define ACQST_CLEAN_CYC     16'h0010
`define ACQST_ROW_CYC       16'h0004

`endif

// ### acqst_pkg.sv
package acqst_pkg;

    typedef enum logic [3:0] {
        SRC_ACQUIRING,
        SRC_EXPOSE_EFF,
        SRC_EXPOSE_PROG,
        SRC_ROW_SHIFT,
        SRC_ALWAYS_HIGH,
        SRC_READOUT,
        SRC_SHUTTER,
        SRC_TRIG_WAIT
    } acqst_src_t;

    typedef enum logic [1:0] {
        TRIG_FREE_RUN,
        TRIG_PER_FRAME,
        TRIG_BULB
    } acqst_trig_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CLEAN,
        ST_PREOPEN,
        ST_WAIT_TRIG,
        ST_CONT_CLEAN,
        ST_EXPOSE,
        ST_SHIFT,
        ST_READOUT,
        ST_HOLD
    } acqst_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } acqst_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } acqst_apb_rsp_t;

    typedef struct packed {
        logic        per_frame;
        logic        invert;
        acqst_src_t  src;
        acqst_trig_t trig_mode;
        logic        falling;
        logic        cont_clean;
        logic        preopen;
        logic        kinetics;
        logic [7:0]  subframes;
    } acqst_cfg_t;

    typedef struct packed {
        acqst_state_t st;
        acqst_cfg_t   cfg;
        acqst_cfg_t   live;
        logic [31:0]  frames;
        logic [31:0]  expose;
        logic [31:0]  cleans;
        logic [31:0]  shift_rows;
        logic [31:0]  read_rows;
        logic [31:0]  shut_open;
        logic [31:0]  cnt;
        logic [15:0]  sub;
        logic [31:0]  frame_no;
        logic [7:0]   kin_no;
        logic         trig_prev;
        logic         trig_seen;
        logic         acquiring;
        logic         first_done;
        logic         stop_req;
        logic         status_out;
        logic [31:0]  prdata;
    } acqst_state_reg_t;

endpackage

// ### acqst_props.sv
`timescale 1ns/1ns
module acqst_props (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire acqst_pkg::acqst_apb_req_t apb_req,
    input wire acqst_pkg::acqst_apb_rsp_t apb_rsp,
    input wire logic                      trigger_in,
    input wire logic                      status_out,
    input wire logic                      shutter_open,
    input wire logic                      acquiring
);
    import acqst_pkg::*;
    logic        wr, act_edge, src_acq, stop_seen, trig_q;
    logic [31:0] cfg_w, live, frames_w;
    logic [7:0]  since, edge_age;
    // Writes land at the access edge since pready is tied high
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign act_edge = (trig_q != trigger_in) && (trigger_in != live[10]);
    assign src_acq = live[7:4] == 4'h0;
    // Shadow settings; source and polarity only go live at a start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_w     <= '0;
            live      <= '0;
            frames_w  <= 32'h0000_0001;
            since     <= 8'hff;
            edge_age  <= 8'hff;
            stop_seen <= 1'b0;
            trig_q    <= 1'b0;
        end else begin
            trig_q   <= trigger_in;
            since    <= (since == 8'hff) ? since : since + 8'h01;
            edge_age <= act_edge ? 8'h00 : (edge_age == 8'hff) ? edge_age : edge_age + 8'h01;
            if (wr && apb_req.paddr == 12'h004) cfg_w <= apb_req.pwdata;
            if (wr && apb_req.paddr == 12'h008) frames_w <= apb_req.pwdata;
            if (wr && apb_req.paddr == 12'h000 && apb_req.pwdata[1]) stop_seen <= 1'b1;
            if (wr && apb_req.paddr == 12'h000 && apb_req.pwdata[0]) begin
                live      <= cfg_w;
                since     <= 8'h00;
                stop_seen <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_acq_idle_low: assert property ((src_acq && !live[1] && since > 8'h03 && !acquiring) [*3] |-> !status_out)
        else $error("status high while not acquiring");
    a_acq_inv_low: assert property ((src_acq && live[1] && since > 8'h03 && acquiring) [*3] |-> !status_out)
        else $error("inverted status not low while acquiring");
    a_const_high: assert property (live[7:4] == 4'h4 && since > 8'h03 |-> status_out)
        else $error("constant source not high");
    a_shutter_cover: assert property ((live[7:4] == 4'h6 && !live[1] && shutter_open) [*2] |-> status_out)
        else $error("shutter source low while shutter open");
    a_clean_first: assert property ($rose(acquiring) && !live[0] |-> since >= 8'd63)
        else $error("acquiring rose before cleaning ended");
    a_frame_end: assert property ($rose(acquiring) && frames_w == 32'h1 && live[9:8] == 2'b00 |-> ##[1:400] !acquiring)
        else $error("single frame run did not end");
    a_free_hold: assert property ($fell(acquiring) && frames_w == '0 |-> stop_seen)
        else $error("free run ended without stop");
    a_trig_drop: assert property ($fell(status_out) && shutter_open && live[7:4] == 4'h7 && live[11:10] == 2'b01
        && !live[1] && !stop_seen |-> edge_age <= 8'd4)
        else $error("trigger wait dropped without active edge");
    c_start: cover property ($rose(acquiring));
    c_trig: cover property ($fell(status_out) && live[7:4] == 4'h7);
    c_stop: cover property ($fell(acquiring) && stop_seen);
endmodule
bind acqst_core acqst_props chk_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .trigger_in(trigger_in), .status_out(status_out), .shutter_open(shutter_open), .acquiring(acquiring));

// ### acqst_trig_src.sv
`timescale 1ns/1ns
module acqst_trig_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       fire,
    input  wire logic [7:0] width,
    output logic            trigger_in
);
    logic [7:0] left_reg;
    // One pulse per request; the line rests low so both edges are seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_reg   <= 8'h00;
            trigger_in <= 1'b0;
        end else if (fire) begin
            left_reg   <= width;
            trigger_in <= 1'b1;
        end else if (left_reg != 8'h00) begin
            left_reg   <= left_reg - 8'h01;
            trigger_in <= (left_reg != 8'h01);
        end
    end
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import acqst_pkg::*;
    localparam logic [31:0] RST_VALS [7] = '{32'h0, 32'h1, 32'h64, 32'h4, 32'h8, 32'h20, 32'h10};
    logic           pclk, presetn, fire, trigger_in, status_out, shutter_open, acquiring;
    logic [7:0]     width;
    logic [31:0]    rnd, e, exp_q[$];
    acqst_apb_req_t req;
    acqst_apb_rsp_t rsp;
    int             num_errors, tests_run, cyc, hi, n, w, want[8];
    acqst_core dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .trigger_in(trigger_in),
        .status_out(status_out), .shutter_open(shutter_open), .acquiring(acquiring));
    acqst_trig_src ext_u (.pclk(pclk), .presetn(presetn), .fire(fire), .width(width), .trigger_in(trigger_in));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Setup then access, held until pready is seen; one idle edge after
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        req <= '0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic count_hi(input int len);
        hi = 0;
        repeat (len) begin
            @(posedge pclk);
            hi += (status_out === 1'b1);
        end
    endtask
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Read data judged against the oldest note, then hang guard
    always @(posedge pclk) begin
        cyc++;
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) check("prdata", rsp.prdata, exp_q.pop_front());
        if (cyc > 40000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        req = '0;
        presetn = 1'b0;
        fire = 1'b0;
        width = 8'h00;
        rnd = xs(32'h74d1_5b2f);
        e = 32'd20 + {26'd0, rnd[5:0]};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (RST_VALS[i]) rd(12'(4 * i + 4), RST_VALS[i]);
        rd(12'h040, 32'h0);
        apb(1'b1, 12'h00c, e);
        rd(12'h00c, e);
        $display("test registers done");
        // Every source, both polarities; high time over a fixed window
        want = '{int'(e) + 160, int'(e), int'(e), 0, 700, 128, int'(e) + 16, 0};
        for (int inv = 0; inv < 2; inv++) begin
            for (int s = 0; s < 8; s++) begin
                apb(1'b1, 12'h004, 32'((s << 4) | (inv << 1)));
                apb(1'b1, 12'h000, 32'h1);
                count_hi(700);
                w = (s == 4 || inv == 0) ? want[s] : 700 - want[s];
                if (s != 3) check("source high time", hi, w);
                else check("row pulses", hi != 0 && hi != 700, 1);
            end
        end
        $display("test sources done");
        apb(1'b1, 12'h004, 32'h0002_2051);
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b1, 12'h000, 32'h1);
        count_hi(1400);
        check("one frame per start", hi, 128);
        apb(1'b1, 12'h000, 32'h2);
        check("held between frames", acquiring, 1);
        apb(1'b1, 12'h000, 32'h1);
        count_hi(700);
        check("next frame after restart", hi, 128);
        apb(1'b1, 12'h000, 32'h2);
        check("last frame ends run", acquiring, 0);
        $display("test per frame done");
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h1);
        count_hi(1200);
        check("free run held", acquiring, 1);
        apb(1'b1, 12'h000, 32'h2);
        repeat (400) @(posedge pclk);
        check("free run halted", acquiring, 0);
        $display("test free run done");
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h004, 32'h570);
        apb(1'b1, 12'h000, 32'h1);
        n = 0;
        while (status_out !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        check("armed", status_out, 1);
        fire <= 1'b1;
        width <= 8'd10;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (7) @(posedge pclk);
        check("wrong edge ignored", status_out, 1);
        repeat (10) @(posedge pclk);
        check("trigger taken", status_out, 0);
        repeat (400) @(posedge pclk);
        $display("test trigger done");
        conclude();
    end
endmodule
